// file: hw/pfirc_cfg.svh
// How it works
// - Mode 0 disables, 2 enables; 1,3 reserved
// - First tap coefficient register at 0x418
// - Second tap coefficient register at 0x41A
// - Third tap coefficient register at 0x41C
// - Side taps signed 12-bit, upper bits reserved
// - Fourth tap coefficient register at 0x41E
// - Side-tap LSB weight set by field 0-6
// - Centre tap uses 18-bit signed coefficient
`ifndef PFIRC_CFG_SVH
`define PFIRC_CFG_SVH

// Register indices; byte address is four times the index
`define PFIRC_IDX_CFG      14'h0400
`define PFIRC_IDX_TAP0     14'h0418
`define PFIRC_IDX_TAP1     14'h041A
`define PFIRC_IDX_TAP2     14'h041C
`define PFIRC_IDX_TAP3     14'h041E
`define PFIRC_IDX_CENTRE   14'h0420
`define PFIRC_IDX_LINK     14'h0200
`define PFIRC_IDX_STATUS   14'h0201

// Configuration register fields
`define PFIRC_CFG_W        8
`define PFIRC_CFG_RST      8'h00
`define PFIRC_CFG_MODE_LSB 0
`define PFIRC_CFG_SCW_LSB  2
`define PFIRC_CFG_MERGE    5
`define PFIRC_CFG_SHARE    6
`define PFIRC_MODE_OFF     2'h0
`define PFIRC_MODE_ON      2'h2
`define PFIRC_SCW_MAX      3'h6

// Coefficient fields
`define PFIRC_SIDE_W       12
`define PFIRC_CENTRE_W     18
`define PFIRC_COEF_RST     18'h00000
`define PFIRC_FRAC_BITS    16

// Status register fields
`define PFIRC_ST_ACTIVE    0
`define PFIRC_ST_CNT_LSB   1
`define PFIRC_ST_VIOL      8

`endif

// file: hw/pfirc_pkg.sv
package pfirc_pkg;
    typedef enum logic [1:0] {
        PFIRC_MODE_OFF_E  = 2'h0,
        PFIRC_MODE_RSV1_E = 2'h1,
        PFIRC_MODE_ON_E   = 2'h2,
        PFIRC_MODE_RSV3_E = 2'h3
    } pfirc_mode_t;
endpackage

// file: hw/pfirc_buf.sv
`timescale 1ns/10ps
// Two-entry buffer; head entry drives the output directly
module pfirc_buf #(
    parameter int W     = 12,
    parameter int DEPTH = 2
) (
    input  wire logic         i_mclk,
    input  wire logic         i_sys_rst,
    input  wire logic [W-1:0] i_data,
    input  wire logic         i_valid,
    output logic              o_ready,
    output logic [W-1:0]      o_data,
    output logic              o_valid,
    input  wire logic         i_ready,
    output logic [1:0]        o_count
);
    initial begin
        if (DEPTH != 2) begin
            $error("pfirc_buf serves a depth of two only");
        end
    end

    logic [W-1:0] ent1_reg;
    logic [1:0]   cnt_reg;
    wire          push = i_valid & o_ready;
    wire          pop  = o_valid & i_ready;
    wire  [1:0]   cnt_next = cnt_reg + {1'b0, push} - {1'b0, pop};
    wire          load0_in = push & ((pop & (cnt_reg == 2'h1)) |
                                     (!pop & (cnt_reg == 2'h0)));
    wire          load1_in = push & ((!pop & (cnt_reg == 2'h1)) |
                                     (pop & (cnt_reg == 2'h2)));
    wire          shift    = pop & (cnt_reg == 2'h2);

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            cnt_reg  <= 2'h0;
            o_valid  <= 1'b0;
            o_ready  <= 1'b0;
            o_data   <= '0;
            ent1_reg <= '0;
        end else begin
            cnt_reg <= cnt_next;
            o_valid <= cnt_next != 2'h0;
            o_ready <= cnt_next != 2'h2;
            if (shift) begin
                o_data <= ent1_reg;
            end else if (load0_in) begin
                o_data <= i_data;
            end
            if (load1_in) begin
                ent1_reg <= i_data;
            end
        end
    end

    assign o_count = cnt_reg;
endmodule

// file: hw/pfirc_top.sv
`timescale 1ns/10ps
`include "pfirc_cfg.svh"
// Programmable FIR control: registers, coefficient store, sample path
module pfirc_top #(
    parameter int SMP_W = 12
) (
    input  wire logic             i_mclk,
    input  wire logic             i_sys_rst,
    input  wire logic             i_wb_cyc,
    input  wire logic             i_wb_stb,
    input  wire logic             i_wb_we,
    input  wire logic [15:0]      i_wb_adr,
    input  wire logic [3:0]       i_wb_sel,
    input  wire logic [31:0]      i_wb_dat,
    output logic [31:0]           o_wb_dat,
    output logic                  o_wb_ack,
    input  wire logic [SMP_W-1:0] i_smp_data,
    input  wire logic             i_smp_valid,
    output logic                  o_smp_ready,
    output logic [SMP_W-1:0]      o_smp_data,
    output logic                  o_smp_valid,
    input  wire logic             i_smp_ready,
    output logic                  o_serial_link_enable,
    output logic                  o_filter_merge_bit,
    output logic                  o_filter_share
);
    localparam int SW   = `PFIRC_SIDE_W;
    localparam int CW   = `PFIRC_CENTRE_W;
    localparam int ACCW = SMP_W + CW + 4;

    initial begin
        if (SMP_W < 2 || SMP_W > 16) begin
            $error("pfirc_top sample width out of range");
        end
    end

    // Register state
    logic [`PFIRC_CFG_W-1:0] fir_config_reg;
    logic [SW-1:0]           tap_reg [4];
    logic [CW-1:0]           centre_reg;
    logic                    viol_reg;
    logic [SMP_W-1:0]        hist_reg [4];

    // Bus decode
    wire        req      = i_wb_cyc & i_wb_stb & !o_wb_ack;
    wire        wr       = req & i_wb_we;
    wire [13:0] idx      = i_wb_adr[15:2];
    wire        hit_cfg  = idx == `PFIRC_IDX_CFG;
    wire        hit_t0   = idx == `PFIRC_IDX_TAP0;
    wire        hit_t1   = idx == `PFIRC_IDX_TAP1;
    wire        hit_t2   = idx == `PFIRC_IDX_TAP2;
    wire        hit_t3   = idx == `PFIRC_IDX_TAP3;
    wire        hit_cen  = idx == `PFIRC_IDX_CENTRE;
    wire        hit_link = idx == `PFIRC_IDX_LINK;
    wire        hit_st   = idx == `PFIRC_IDX_STATUS;
    wire [3:0]  hit_tap  = {hit_t3, hit_t2, hit_t1, hit_t0};
    wire [31:0] wmask    = {{8{i_wb_sel[3]}}, {8{i_wb_sel[2]}},
                            {8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};

    // Byte-lane merge of write data over a stored value
    function automatic logic [31:0] merge_w(input logic [31:0] old,
                                            input logic [31:0] nw,
                                            input logic [31:0] m);
        merge_w = (old & ~m) | (nw & m);
    endfunction

    wire [31:0] cfg_w  = merge_w({24'h0, fir_config_reg}, i_wb_dat, wmask);
    wire [31:0] cen_w  = merge_w({14'h0, centre_reg}, i_wb_dat, wmask);
    wire [31:0] link_w = merge_w({31'h0, o_serial_link_enable},
                                 i_wb_dat, wmask);
    wire        cfg_touch = wr & (hit_cfg | hit_cen | (|hit_tap));
    wire        viol_set  = cfg_touch & o_serial_link_enable;
    wire        viol_clr  = wr & hit_st & i_wb_sel[1] &
                            i_wb_dat[`PFIRC_ST_VIOL];

    // Mode decode: reserved codes leave the filter off
    pfirc_pkg::pfirc_mode_t mode;
    assign mode = pfirc_pkg::pfirc_mode_t'(
        fir_config_reg[`PFIRC_CFG_MODE_LSB +: 2]);
    wire        filt_on = mode == pfirc_pkg::PFIRC_MODE_ON_E;
    wire [2:0]  scw_raw = fir_config_reg[`PFIRC_CFG_SCW_LSB +: 3];
    wire [2:0]  scw     = (scw_raw > `PFIRC_SCW_MAX) ?
                          `PFIRC_SCW_MAX : scw_raw;
    wire [1:0]  buf_cnt;

    // Read mux
    logic [31:0] rd_data;
    always_comb begin
        rd_data = 32'h0;
        if (hit_cfg) begin
            rd_data = {24'h0, fir_config_reg};
        end else if (|hit_tap) begin
            for (int k = 0; k < 4; k++) begin
                if (hit_tap[k]) begin
                    rd_data = {20'h0, tap_reg[k]};
                end
            end
        end else if (hit_cen) begin
            rd_data = {14'h0, centre_reg};
        end else if (hit_link) begin
            rd_data = {31'h0, o_serial_link_enable};
        end else if (hit_st) begin
            rd_data[`PFIRC_ST_ACTIVE]          = filt_on;
            rd_data[`PFIRC_ST_CNT_LSB +: 2]    = buf_cnt;
            rd_data[`PFIRC_ST_VIOL]            = viol_reg;
        end
    end

    // Bus slave: one-cycle answer, unmapped reads zero
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            o_wb_ack <= 1'b0;
            o_wb_dat <= 32'h0;
        end else begin
            o_wb_ack <= req;
            o_wb_dat <= req ? rd_data : 32'h0;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            fir_config_reg       <= `PFIRC_CFG_RST;
            o_serial_link_enable <= 1'b0;
        end else begin
            if (wr & hit_cfg) begin
                fir_config_reg <= {1'b0, cfg_w[6:0]};
            end
            if (wr & hit_link) begin
                o_serial_link_enable <= link_w[0];
            end
        end
    end

    // Coefficient store, signed values in the low bits
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            for (int k = 0; k < 4; k++) begin
                tap_reg[k] <= SW'(`PFIRC_COEF_RST);
            end
            centre_reg <= `PFIRC_COEF_RST;
        end else begin
            for (int k = 0; k < 4; k++) begin
                if (wr & hit_tap[k]) begin
                    tap_reg[k] <= SW'(merge_w({20'h0, tap_reg[k]},
                                              i_wb_dat, wmask));
                end
            end
            if (wr & hit_cen) begin
                centre_reg <= cen_w[CW-1:0];
            end
        end
    end

    // Sticky flag for settings written while the link runs; set wins
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            viol_reg <= 1'b0;
        end else if (viol_set) begin
            viol_reg <= 1'b1;
        end else if (viol_clr) begin
            viol_reg <= 1'b0;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            o_filter_merge_bit <= 1'b0;
            o_filter_share     <= 1'b0;
        end else begin
            o_filter_merge_bit <= fir_config_reg[`PFIRC_CFG_MERGE];
            o_filter_share     <= fir_config_reg[`PFIRC_CFG_SHARE];
        end
    end

    // Sample path: tap k weights the sample k steps back
    wire              take = i_smp_valid & o_smp_ready;
    wire [SMP_W-1:0]  x [5];
    assign x[0] = i_smp_data;
    for (genvar g = 0; g < 4; g++) begin : g_hist
        assign x[g+1] = hist_reg[g];
    end

    logic signed [ACCW-1:0] acc;
    logic signed [ACCW-1:0] term;
    logic signed [ACCW-1:0] scaled;
    logic [SMP_W-1:0]       filt_out;
    always_comb begin
        acc  = ACCW'(signed'(centre_reg) * signed'(x[4]));
        term = '0;
        for (int k = 0; k < 4; k++) begin
            term = ACCW'(signed'(tap_reg[k]) * signed'(x[k]));
            acc  = acc + (term <<< scw);
        end
        scaled = acc >>> `PFIRC_FRAC_BITS;
        if (scaled > ACCW'(signed'({1'b0, {(SMP_W-1){1'b1}}}))) begin
            filt_out = {1'b0, {(SMP_W-1){1'b1}}};
        end else if (scaled < ACCW'(signed'({1'b1, {(SMP_W-1){1'b0}}})))
        begin
            filt_out = {1'b1, {(SMP_W-1){1'b0}}};
        end else begin
            filt_out = scaled[SMP_W-1:0];
        end
    end

    wire [SMP_W-1:0] path_data = filt_on ? filt_out : i_smp_data;

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            for (int k = 0; k < 4; k++) begin
                hist_reg[k] <= '0;
            end
        end else if (take) begin
            hist_reg[0] <= i_smp_data;
            for (int k = 1; k < 4; k++) begin
                hist_reg[k] <= hist_reg[k-1];
            end
        end
    end

    pfirc_buf #(
        .W     (SMP_W),
        .DEPTH (2)
    ) u_buf (
        .i_mclk    (i_mclk),
        .i_sys_rst (i_sys_rst),
        .i_data    (path_data),
        .i_valid   (i_smp_valid),
        .o_ready   (o_smp_ready),
        .o_data    (o_smp_data),
        .o_valid   (o_smp_valid),
        .i_ready   (i_smp_ready),
        .o_count   (buf_cnt)
    );
endmodule

// file: verif/pfirc_checker.sv
`timescale 1ns/10ps
module pfirc_checker #(
    parameter int SMP_W = 12
) (
    input wire logic             i_mclk,
    input wire logic             i_sys_rst,
    input wire logic             i_wb_cyc,
    input wire logic             i_wb_stb,
    input wire logic             i_wb_we,
    input wire logic [15:0]      i_wb_adr,
    input wire logic [3:0]       i_wb_sel,
    input wire logic [31:0]      i_wb_dat,
    input wire logic [31:0]      o_wb_dat,
    input wire logic             o_wb_ack,
    input wire logic [SMP_W-1:0] i_smp_data,
    input wire logic             i_smp_valid,
    input wire logic             o_smp_ready,
    input wire logic [SMP_W-1:0] o_smp_data,
    input wire logic             o_smp_valid,
    input wire logic             i_smp_ready,
    input wire logic             o_serial_link_enable,
    input wire logic             o_filter_merge_bit
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_sys_rst);
    logic [1:0] mode_reg;
    wire        wr_ack  = o_wb_ack && i_wb_we && i_wb_sel[0];
    wire        cfg_wr  = wr_ack && i_wb_adr == 16'h1000;
    wire        link_wr = wr_ack && i_wb_adr == 16'h0800;
    wire        cfg_take = i_wb_cyc && i_wb_stb && !o_wb_ack && i_wb_we &&
                           i_wb_sel[0] && i_wb_adr == 16'h1000;
    // Mode as the design takes it, at the edge the write lands
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst)
            mode_reg <= 2'h0;
        else if (cfg_take)
            mode_reg <= i_wb_dat[1:0];
    end
    a_ack_next_edge: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack
        |=> o_wb_ack) else $error("bus request not answered");
    a_ack_one_pulse: assert property (o_wb_ack |=> !o_wb_ack)
        else $error("ack longer than one cycle");
    a_read_data_idle: assert property (!o_wb_ack |-> o_wb_dat == 32'h0)
        else $error("read data without ack");
    a_bypass_sample: assert property (mode_reg != 2'h2 && i_smp_valid
        && o_smp_ready && !o_smp_valid |=> o_smp_valid
        && o_smp_data == $past(i_smp_data)) else $error("bypass mismatch");
    a_stall_holds_word: assert property (o_smp_valid && !i_smp_ready
        |=> o_smp_valid && $stable(o_smp_data)) else $error("word lost");
    a_merge_follows: assert property (cfg_wr |-> ##2
        o_filter_merge_bit == $past(i_wb_dat[5], 2))
        else $error("merge bit not updated");
    a_link_follows: assert property (link_wr |-> ##2
        o_serial_link_enable == $past(i_wb_dat[0], 2))
        else $error("link enable not updated");
    a_reset_clears: assert property ($fell(i_sys_rst) |-> !o_smp_valid
        && !o_filter_merge_bit && !o_serial_link_enable)
        else $error("outputs not cleared by reset");
endmodule

bind pfirc_top pfirc_checker #(.SMP_W(SMP_W)) pfirc_checker_i (
    .i_mclk, .i_sys_rst, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr,
    .i_wb_sel, .i_wb_dat, .o_wb_dat, .o_wb_ack, .i_smp_data, .i_smp_valid,
    .o_smp_ready, .o_smp_data, .o_smp_valid, .i_smp_ready,
    .o_serial_link_enable, .o_filter_merge_bit);

// file: verif/pfirc_smp_model.sv
`timescale 1ns/10ps
// Converter sample source and downstream link sink
module pfirc_smp_model (
    input  wire logic        i_mclk,
    input  wire logic        i_stall,
    input  wire logic        i_ready,
    input  wire logic [11:0] i_data,
    input  wire logic        i_valid,
    output logic [11:0]      o_data,
    output logic             o_valid,
    output logic             o_ready
);
    logic [11:0] tx_q[$];
    logic [11:0] rx_q[$];
    initial begin
        o_data = 12'h000;
        o_valid = 1'h0;
    end
    assign o_ready = !i_stall;
    always @(posedge i_mclk) begin
        if (i_valid && o_ready)
            rx_q.push_back(i_data);
        if (!o_valid || i_ready) begin
            if (tx_q.size() > 0) begin
                o_valid <= 1'h1;
                o_data  <= tx_q.pop_front();
            end else begin
                // Idle lines toggle so no stale word looks valid
                o_valid <= 1'h0;
                o_data  <= ~o_data;
            end
        end
    end
endmodule

// file: verif/tb.sv
`timescale 1ns/10ps
module tb;
    logic        i_mclk = 1'h0;
    logic        i_sys_rst = 1'h1;
    logic        cyc = 1'h0, stb = 1'h0, we = 1'h0, stall = 1'h0;
    logic [15:0] adr = 16'h0000;
    logic [31:0] wdat = 32'h0, rdat, q;
    logic [11:0] sd, qd;
    logic        ack, sv, sr, qv, qr, link, merge, share;
    int          miscompares = 0, n_checks = 0, cycles = 0;
    logic [15:0] adrs [6] = '{16'h1000, 16'h1060, 16'h1068, 16'h1070,
                              16'h1078, 16'h1080};
    logic [1:0]  pm [3] = '{2'h0, 2'h1, 2'h3};
    logic [11:0] tap [3] = '{12'h010, 12'hFF0, 12'h000};
    logic [31:0] ctr [3] = '{32'h0, 32'h0, 32'h0001_0000};
    logic [2:0]  scw [3] = '{3'h6, 3'h2, 3'h0};
    logic [11:0] fy [3] = '{12'h010, 12'hFFF, 12'h100};
    always #5 i_mclk = ~i_mclk;
    pfirc_top pfirc_top_i (.i_mclk, .i_sys_rst, .i_wb_cyc(cyc),
        .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hF),
        .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack), .i_smp_data(sd),
        .i_smp_valid(sv), .o_smp_ready(sr), .o_smp_data(qd),
        .o_smp_valid(qv), .i_smp_ready(qr), .o_serial_link_enable(link),
        .o_filter_merge_bit(merge), .o_filter_share(share));
    pfirc_smp_model pfirc_smp_model_i (.i_mclk, .i_stall(stall),
        .i_ready(sr), .i_data(qd), .i_valid(qv), .o_data(sd),
        .o_valid(sv), .o_ready(qr));
    task automatic report_and_stop;
        if (miscompares == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] got, exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic bus(input logic w, input logic [15:0] a,
                       input logic [31:0] d);
        @(posedge i_mclk);
        cyc <= 1'h1; stb <= 1'h1; we <= w; adr <= a; wdat <= d;
        @(posedge i_mclk);
        while (ack !== 1'h1) @(posedge i_mclk);
        q = rdat;
        cyc <= 1'h0; stb <= 1'h0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [31:0] e,
                      input string nm);
        bus(1'h0, a, 32'h0);
        chk(nm, q, e);
    endtask
    task automatic send(input logic [11:0] x, input int n);
        pfirc_smp_model_i.rx_q.delete();
        repeat (n) pfirc_smp_model_i.tx_q.push_back(x);
    endtask
    task automatic drain(input int n);
        while (pfirc_smp_model_i.rx_q.size() < n) @(posedge i_mclk);
    endtask
    always @(posedge i_mclk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            report_and_stop();
        end
    end
    initial begin
        repeat (4) @(posedge i_mclk);
        i_sys_rst <= 1'h0;
        for (int k = 0; k < 6; k++) rd(adrs[k], 32'h0, "reset");
        for (int k = 1; k < 5; k++) bus(1'h1, adrs[k], 32'hFFFF_F800 | k);
        for (int k = 1; k < 5; k++) rd(adrs[k], 32'h800 | k, "tap");
        bus(1'h1, 16'h1080, 32'hFFFF_FFFF);
        rd(16'h1080, 32'h0003_FFFF, "centre");
        bus(1'h1, 16'h2000, 32'hFFFF_FFFF);
        rd(16'h2000, 32'h0, "unmapped");
        bus(1'h1, 16'h1000, 32'h0000_00FA);
        rd(16'h1000, 32'h0000_007A, "config");
        chk("merge", {31'h0, merge}, 32'h1);
        chk("share", {31'h0, share}, 32'h1);
        // Off and reserved modes pass samples; a stall fills the buffer
        foreach (pm[m]) begin
            bus(1'h1, 16'h1000, {30'h0, pm[m]});
            stall <= 1'h1;
            send(12'h5A0 + 12'(m), 4);
            repeat (8) @(posedge i_mclk);
            chk("full ready", {31'h0, sr}, 32'h0);
            stall <= 1'h0;
            drain(4);
            for (int k = 0; k < 4; k++) chk("bypass",
                pfirc_smp_model_i.rx_q[k], 32'h5A0 + m);
        end
        foreach (fy[c]) begin
            bus(1'h1, 16'h0800, 32'h0);
            for (int k = 1; k < 5; k++) bus(1'h1, adrs[k], {20'h0, tap[c]});
            bus(1'h1, 16'h1080, ctr[c]);
            bus(1'h1, 16'h1000, {27'h0, scw[c], 2'h2});
            send(12'h100, 6);
            drain(6);
            chk("filtered", pfirc_smp_model_i.rx_q[5], fy[c]);
            bus(1'h1, 16'h0800, 32'h1);
            @(posedge i_mclk);
            chk("link", {31'h0, link}, 32'h1);
        end
        bus(1'h1, 16'h0800, 32'h0);
        rd(16'h0800, 32'h0, "link reg");
        rd(16'h0804, 32'h0000_0001, "status");
        report_and_stop();
    end
endmodule
